// ### logic/rmsc_core.sv
// reset release, strap latching, fetch gating, clock image and address decode
//
// Contract
// - reset enters asynchronously on the pin, exits synchronised to master clock
// - first processor fetch held off 80 master clock cycles after pin release; the code enables fetch on the 82nd cycle
// - any reset defaults peripheral registers and forces fetch from address zero
// - watchdog reset acts like pin reset but leaves strap modes unchanged
// - pin reset wins when pin and watchdog reset coincide
// - tri-state mode latched when strap low for last 10 cycles before release
// - tri-state mode disables every controller output driver
// - tri-state mode lets an external programmer reach the flash directly
// - outside tri-state mode, clock output pin copies master clock during and after reset until reassigned
// - after reset every peripheral I/O line is an input
// - address space: low 4 MB internal, top 4 MB peripherals, middle external
// - all regions little-endian only, no big-endian option
// - boot width strap sampled over last 10 cycles before pin release
// - strap 1 selects 8-bit boot memory, 0 selects 16-bit, both on select zero
// - remap undone only by internal reset or pin reset
`include "rmsc_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module rmsc_core
	import rmsc_pkg::*;
#(
	parameter int FETCH_DELAY = `RMSC_FETCH_DELAY_CYC,
	parameter int STRAP_WIN = `RMSC_STRAP_WINDOW_CYC
) (
	input wire logic clk_sys, // master clock from the clock input pin
	input wire logic hw_reset_in_n, // hardware reset pin, active low
	input wire logic wdog_reset_req, // watchdog internal reset request, one-cycle pulse
	input wire logic tristate_strap_n, // tri-state strap, low selects tri-state
	input wire logic boot_width_strap, // boot width strap
	input wire logic remap_cmd, // remap command pulse from software
	input wire logic clkout_as_gpio, // software gave clock output pin to the I/O controller
	input wire logic [31:0] cpu_addr, // processor address
	output logic periph_rst_n_q, // peripheral register reset, active low
	output logic cpu_fetch_en_q, // processor allowed to fetch
	output logic pc_zero_q, // next fetch from address zero
	output logic tristate_mode_q, // tri-state mode latched
	output logic boot_8bit_q, // 1: 8-bit boot on select zero, 0: 16-bit
	output logic out_drv_en_q, // master enable for controller output drivers
	output logic flash_direct_q, // flash pins routed to package pins
	output logic io_dir_out_en_q, // peripheral I/O lines may drive
	output logic clkout_pin_en_q, // clock output pin carries master clock image
	output logic remap_q, // remap in effect
	output logic [1:0] area_q, // decoded address region
	output logic little_endian_q // byte order is little-endian
);
	// ==================================================
	// reset release synchroniser and watchdog merge
	logic rel_s1_q, rel_s2_q;
	always_ff @(posedge clk_sys or negedge hw_reset_in_n) begin
		if (!hw_reset_in_n) begin
			rel_s1_q <= 1'b0;
			rel_s2_q <= 1'b0;
		end else begin
			rel_s1_q <= 1'b1;
			rel_s2_q <= rel_s1_q;
		end
	end
	// pin reset is async and dominates any watchdog request
	logic int_rst; // internal reset in force this cycle
	assign int_rst = !rel_s2_q || wdog_reset_req;
	// ==================================================
	// strap sampling: only a pin reset resamples
	logic tri_low, boot_low, boot_high;
	rmsc_low_window #(.WIN(STRAP_WIN)) u_tri_win (
		.clk_sys(clk_sys),
		.hw_reset_in_n(1'b1),
		.level_in(tristate_strap_n),
		.all_low(tri_low)
	);
	rmsc_low_window #(.WIN(STRAP_WIN)) u_boot_win (
		.clk_sys(clk_sys),
		.hw_reset_in_n(1'b1),
		.level_in(boot_width_strap),
		.all_low(boot_low)
	);
	rmsc_low_window #(.WIN(STRAP_WIN)) u_boot_hi (
		.clk_sys(clk_sys),
		.hw_reset_in_n(1'b1),
		.level_in(!boot_width_strap),
		.all_low(boot_high)
	);
	logic pin_held_q; // pin reset was seen, straps still pending
	logic [1:0] pin_shadow_q; // reset pin level history over the last two clocks
	always_ff @(posedge clk_sys) begin
		pin_shadow_q <= {pin_shadow_q[0], hw_reset_in_n};
	end
	logic pin_rise;
	assign pin_rise = pin_shadow_q[0] && !pin_shadow_q[1];
	always_ff @(posedge clk_sys or negedge hw_reset_in_n) begin
		if (!hw_reset_in_n) begin
			pin_held_q <= 1'b1;
		end else if (pin_rise) begin
			pin_held_q <= 1'b0;
		end
	end
	// straps are latched on the second edge with the pin released, using
	// the window that closed with the rising edge; watchdog never touches them
	always_ff @(posedge clk_sys) begin
		if (pin_rise && pin_held_q) begin
			tristate_mode_q <= tri_low;
			if (boot_high) begin
				boot_8bit_q <= `RMSC_BOOT_8BIT;
			end else if (boot_low) begin
				boot_8bit_q <= `RMSC_BOOT_16BIT;
			end else begin
				boot_8bit_q <= boot_width_strap;
			end
		end
	end
	// ==================================================
	// start-up sequencer and fetch delay counter
	rmsc_state_t state_q;
	localparam int FCW = $clog2(FETCH_DELAY + 1);
	logic [FCW-1:0] fetch_cnt_q;
	always_ff @(posedge clk_sys or negedge hw_reset_in_n) begin
		if (!hw_reset_in_n) begin
			state_q <= RMSC_ST_RESET;
			fetch_cnt_q <= '0;
		end else if (wdog_reset_req) begin
			state_q <= RMSC_ST_RESET;
			fetch_cnt_q <= '0;
		end else begin
			case (state_q)
				RMSC_ST_RESET: begin
					if (rel_s2_q) begin
						state_q <= RMSC_ST_WAIT;
						// the release synchroniser has already used two cycles
						fetch_cnt_q <= FCW'(2);
					end
				end
				RMSC_ST_WAIT: begin
					if (fetch_cnt_q >= FETCH_DELAY[$clog2(FETCH_DELAY+1)-1:0] - 1'b1) begin
						state_q <= RMSC_ST_RUN;
					end else begin
						fetch_cnt_q <= fetch_cnt_q + 1'b1;
					end
				end
				RMSC_ST_RUN: state_q <= RMSC_ST_RUN;
				default: state_q <= RMSC_ST_RESET;
			endcase
		end
	end
	// ==================================================
	// reset-driven outputs
	always_ff @(posedge clk_sys or negedge hw_reset_in_n) begin
		if (!hw_reset_in_n) begin
			periph_rst_n_q <= 1'b0;
			cpu_fetch_en_q <= 1'b0;
			pc_zero_q <= 1'b1;
			io_dir_out_en_q <= 1'b0;
		end else begin
			periph_rst_n_q <= !int_rst;
			cpu_fetch_en_q <= (state_q == RMSC_ST_RUN) && !wdog_reset_req;
			pc_zero_q <= int_rst || (pc_zero_q && state_q != RMSC_ST_RUN);
			io_dir_out_en_q <= !int_rst && io_dir_out_en_q;
		end
	end
	// ==================================================
	// remap: set by software, cleared only by a reset
	always_ff @(posedge clk_sys or negedge hw_reset_in_n) begin
		if (!hw_reset_in_n) begin
			remap_q <= 1'b0;
		end else if (int_rst) begin
			remap_q <= 1'b0;
		end else if (remap_cmd) begin
			remap_q <= 1'b1;
		end
	end
	// ==================================================
	// pin drivers, clock image and tri-state
	always_ff @(posedge clk_sys or negedge hw_reset_in_n) begin
		if (!hw_reset_in_n) begin
			clkout_pin_en_q <= 1'b1;
			out_drv_en_q <= 1'b1;
			flash_direct_q <= 1'b0;
		end else begin
			clkout_pin_en_q <= (int_rst || !clkout_as_gpio) && !tristate_mode_q;
			out_drv_en_q <= !tristate_mode_q;
			flash_direct_q <= tristate_mode_q;
		end
	end
	// ==================================================
	// address region decode, little-endian only
	always_ff @(posedge clk_sys or negedge hw_reset_in_n) begin
		if (!hw_reset_in_n) begin
			area_q <= `RMSC_REG_INT_MEM;
			little_endian_q <= 1'b1;
		end else begin
			little_endian_q <= 1'b1;
			if (cpu_addr < `RMSC_INT_MEM_LIMIT) begin
				area_q <= `RMSC_REG_INT_MEM;
			end else if (cpu_addr >= `RMSC_PERIPH_BASE) begin
				area_q <= `RMSC_REG_PERIPH;
			end else begin
				area_q <= `RMSC_REG_EXT_BUS;
			end
		end
	end
	// ==================================================
	// assertions
	logic [7:0] run_cnt_q; // cycles since pin release or the last watchdog request, saturating
	always_ff @(posedge clk_sys or negedge hw_reset_in_n) begin
		if (!hw_reset_in_n) begin
			run_cnt_q <= '0;
		end else if (wdog_reset_req) begin
			run_cnt_q <= '0;
		end else if (run_cnt_q != 8'hff) begin
			run_cnt_q <= run_cnt_q + 8'h01;
		end
	end
	a_fetch_not_early: assert property (@(posedge clk_sys) disable iff (!hw_reset_in_n)
		cpu_fetch_en_q |-> run_cnt_q >= 8'(FETCH_DELAY))
		else $error("fetch enabled before 80 cycles");
	a_fetch_on_time: assert property (@(posedge clk_sys) disable iff (!hw_reset_in_n)
		(run_cnt_q == 8'(FETCH_DELAY + 2)) |-> cpu_fetch_en_q)
		else $error("fetch not enabled in time");
	a_wdog_resets: assert property (@(posedge clk_sys) disable iff (!hw_reset_in_n)
		wdog_reset_req |=> !periph_rst_n_q && !cpu_fetch_en_q)
		else $error("watchdog did not reset");
	a_wdog_keeps_tri: assert property (@(posedge clk_sys) disable iff (!hw_reset_in_n)
		wdog_reset_req |=> $stable(tristate_mode_q))
		else $error("watchdog changed tri-state mode");
	a_remap_clear: assert property (@(posedge clk_sys) disable iff (!hw_reset_in_n)
		(remap_q && !wdog_reset_req) |=> remap_q)
		else $error("remap dropped without reset");
	a_tri_drivers: assert property (@(posedge clk_sys) disable iff (!hw_reset_in_n)
		tristate_mode_q |=> !out_drv_en_q && flash_direct_q)
		else $error("drivers on in tri-state mode");
	a_area_decode: assert property (@(posedge clk_sys) disable iff (!hw_reset_in_n)
		(cpu_addr[31:22] == 10'h3ff) |=> area_q == `RMSC_REG_PERIPH)
		else $error("peripheral region misdecoded");
	a_io_inputs: assert property (@(posedge clk_sys) disable iff (!hw_reset_in_n)
		int_rst |=> !io_dir_out_en_q)
		else $error("io line driving after reset");
	c_fetch_start: cover property (@(posedge clk_sys) disable iff (!hw_reset_in_n) $rose(cpu_fetch_en_q));
	c_wdog_reset: cover property (@(posedge clk_sys) disable iff (!hw_reset_in_n)
		cpu_fetch_en_q ##1 wdog_reset_req);
	c_tri_mode: cover property (@(posedge clk_sys) disable iff (!hw_reset_in_n) tristate_mode_q);
endmodule
`default_nettype wire

// ### logic/rmsc_low_window.sv
// shifts in a strap history and flags when it was low for a whole window length
`timescale 1ns/1ns
`default_nettype none
module rmsc_low_window #(
	parameter int WIN = 10
) (
	input wire logic clk_sys, // master clock
	input wire logic hw_reset_in_n, // async reset
	input wire logic level_in, // sampled strap level
	output logic all_low // low for last WIN cycles
);
	// shift history instead of a counter: it fills with defined samples
	// after WIN clocks even when the reset pin is tied off
	logic [WIN-1:0] hist_q;
	always_ff @(posedge clk_sys or negedge hw_reset_in_n) begin
		if (!hw_reset_in_n) begin
			hist_q <= '1;
		end else begin
			hist_q <= WIN'({hist_q, level_in});
		end
	end
	assign all_low = (hist_q == '0);
endmodule
`default_nettype wire

// ### logic/rmsc_pkg.sv
// types for the reset, mode strap and start-up control block
package rmsc_pkg;
	typedef enum logic [1:0] {
		RMSC_ST_RESET = 2'b00,
		RMSC_ST_WAIT = 2'b01,
		RMSC_ST_RUN = 2'b10
	} rmsc_state_t;
	typedef enum logic [1:0] {
		RMSC_AREA_INT_MEM = 2'b00,
		RMSC_AREA_EXT_BUS = 2'b01,
		RMSC_AREA_PERIPH = 2'b10
	} rmsc_area_t;
endpackage

// ### logic/rmsc_regs.svh
// constants for the reset, mode strap and start-up control block
`ifndef RMSC_REGS_SVH
`define RMSC_REGS_SVH
// ==================================================
// timing counts in master clock cycles
`define RMSC_FETCH_DELAY_CYC 80
`define RMSC_STRAP_WINDOW_CYC 10
// ==================================================
// address map (32-bit)
`define RMSC_INT_MEM_LIMIT 32'h0040_0000
`define RMSC_PERIPH_BASE 32'hffc0_0000
// ==================================================
// region codes
`define RMSC_REG_INT_MEM 2'h0
`define RMSC_REG_EXT_BUS 2'h1
`define RMSC_REG_PERIPH 2'h2
// ==================================================
// boot width strap encodings
`define RMSC_BOOT_8BIT 1'h1
`define RMSC_BOOT_16BIT 1'h0
`endif

// ### tb/rmsc_board.sv
// board-side model: reset pin and the two strap pins
`timescale 1ns/1ns
`default_nettype none
module rmsc_board (
	input wire logic clk_sys, // master clock, free running
	output logic hw_reset_in_n, // reset pin
	output logic tristate_strap_n, // tri-state strap, pulled up
	output logic boot_width_strap // boot width strap
);
	initial begin
		hw_reset_in_n = 1'b0;
		tristate_strap_n = 1'b1;
		boot_width_strap = 1'b0;
	end
	// strap hold runs out two cycles after release; pull-up wins, the other pin flips
	always @(posedge hw_reset_in_n) begin
		repeat (2) @(negedge clk_sys);
		tristate_strap_n <= 1'b1;
		boot_width_strap <= ~boot_width_strap;
	end
	task automatic set_straps(input logic tn, input logic bw);
		@(negedge clk_sys);
		tristate_strap_n <= tn;
		boot_width_strap <= bw;
	endtask
	// straps stay put through the whole reset; the clock runs meanwhile
	task automatic pin_reset(input logic tn, input logic bw, input int cyc);
		@(negedge clk_sys);
		hw_reset_in_n <= 1'b0;
		tristate_strap_n <= tn;
		boot_width_strap <= bw;
		repeat (cyc) @(negedge clk_sys);
		hw_reset_in_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ### tb/tb_rmsc_core.sv
// self-checking bench for the reset, strap and start-up control block
`timescale 1ns/1ns
`default_nettype none
module tb_rmsc_core;
	import rmsc_pkg::*;
	localparam int FD = 8;
	logic clk_sys = 1'b0;
	logic hw_reset_in_n, tristate_strap_n, boot_width_strap;
	logic wdog_reset_req = 1'b0;
	logic remap_cmd = 1'b0;
	logic clkout_as_gpio = 1'b0;
	logic [31:0] cpu_addr = 32'h0000_0000;
	logic periph_rst_n_q, cpu_fetch_en_q, pc_zero_q, tristate_mode_q, boot_8bit_q;
	logic out_drv_en_q, flash_direct_q, io_dir_out_en_q, clkout_pin_en_q, remap_q;
	logic little_endian_q, seen, tn, bw;
	logic [1:0] area_q, ar;
	logic [31:0] a;
	int miscompares = 0;
	int n_checks = 0;
	int n;
	// tri-state strap, boot strap, address, expected region
	logic [35:0] rows [6] = '{{2'h3, 32'h0000_0000, 2'h0}, {2'h2, 32'h003f_ffff, 2'h0},
		{2'h1, 32'h0040_0000, 2'h1}, {2'h0, 32'hffbf_ffff, 2'h1},
		{2'h3, 32'hffc0_0000, 2'h2}, {2'h2, 32'hffff_ffff, 2'h2}};

	always #10 clk_sys = ~clk_sys;

	rmsc_board rmsc_board_i (.clk_sys, .hw_reset_in_n, .tristate_strap_n, .boot_width_strap);
	rmsc_core #(.FETCH_DELAY(FD), .STRAP_WIN(3)) rmsc_core_i (.clk_sys, .hw_reset_in_n,
		.wdog_reset_req, .tristate_strap_n, .boot_width_strap, .remap_cmd,
		.clkout_as_gpio, .cpu_addr, .periph_rst_n_q, .cpu_fetch_en_q, .pc_zero_q,
		.tristate_mode_q, .boot_8bit_q, .out_drv_en_q, .flash_direct_q,
		.io_dir_out_en_q, .clkout_pin_en_q, .remap_q, .area_q, .little_endian_q);

	// ==================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic wait_fetch();
		n = 0;
		while (cpu_fetch_en_q !== 1'b1 && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	task automatic pulse_wdog();
		wdog_reset_req = 1'b1;
		@(negedge clk_sys);
		wdog_reset_req = 1'b0;
	endtask
	// checks made while the pin holds reset, before any clock edge
	task automatic in_reset();
		@(negedge clk_sys);
		#1;
		chk(periph_rst_n_q, 1'h0);
		chk(pc_zero_q, 1'h1);
		chk(cpu_fetch_en_q, 1'h0);
		chk(remap_q, 1'h0);
		chk(clkout_pin_en_q, 1'h1);
	endtask
	task automatic end_sim();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#40000;
		miscompares++;
		end_sim();
	end

	// ==================================================
	// main sequence
	initial begin
		repeat (16) @(negedge clk_sys);
		foreach (rows[i]) begin
			{tn, bw, a, ar} = rows[i];
			rmsc_board_i.pin_reset(tn, bw, 6);
			wait_fetch();
			chk(32'(n >= FD && n <= FD + 2), 32'h1);
			chk(tristate_mode_q, !tn);
			chk(boot_8bit_q, bw);
			chk(out_drv_en_q, tn);
			chk(flash_direct_q, !tn);
			chk(io_dir_out_en_q, 1'h0);
			chk(little_endian_q, 1'h1);
			chk(pc_zero_q, 1'h0);
			cpu_addr = a;
			repeat (2) @(negedge clk_sys);
			chk(area_q, ar);
		end
		// watchdog reset with straps flipped: modes must not follow
		remap_cmd = 1'b1;
		@(negedge clk_sys);
		remap_cmd = 1'b0;
		@(negedge clk_sys);
		chk(remap_q, 1'h1);
		rmsc_board_i.set_straps(1'b0, 1'b1);
		pulse_wdog();
		seen = 1'b0;
		repeat (4) begin
			if (periph_rst_n_q === 1'b0 && cpu_fetch_en_q === 1'b0) seen = 1'b1;
			@(negedge clk_sys);
		end
		chk(seen, 1'h1);
		wait_fetch();
		chk(tristate_mode_q, 1'h0);
		chk(boot_8bit_q, 1'h0);
		chk(remap_q, 1'h0);
		rmsc_board_i.set_straps(1'b1, 1'b0);
		// clock image leaves the pin only once software reassigns it
		chk(clkout_pin_en_q, 1'h1);
		clkout_as_gpio = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk(clkout_pin_en_q, 1'h0);
		clkout_as_gpio = 1'b0;
		// pin reset and watchdog together: pin resamples the straps
		remap_cmd = 1'b1;
		@(negedge clk_sys);
		remap_cmd = 1'b0;
		fork
			rmsc_board_i.pin_reset(1'b1, 1'b1, 6);
			begin
				in_reset();
				pulse_wdog();
			end
		join
		wait_fetch();
		chk(boot_8bit_q, 1'h1);
		chk(tristate_mode_q, 1'h0);
		end_sim();
	end
endmodule
`default_nettype wire
